/* rtl/lrc_pkg.sv */
// constants shared by the ladder reference control logic
package lrc_pkg;

  // ==========================================================================
  // register map (byte addresses, one 32-bit word each)
  // ==========================================================================
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;

  // ==========================================================================
  // control register fields
  // ==========================================================================
  localparam int         POWER_BIT     = 7;
  localparam int         PIN_DRIVE_BIT = 6;
  localparam int         RANGE_BIT     = 5;
  localparam int         SOURCE_BIT    = 4;
  localparam int         TAP_MSB       = 3;
  localparam int         TAP_LSB       = 0;
  localparam int         CTRL_WIDTH    = 8;
  localparam logic [7:0] CTRL_RESET    = 8'h00;

  // ==========================================================================
  // status register fields
  // ==========================================================================
  localparam int STAT_POWER_BIT  = 0;
  localparam int STAT_PIN_BIT    = 1;
  localparam int STAT_COMP_BIT   = 2;
  localparam int STAT_DIG_OE_BIT = 3;
  localparam int STAT_NUM_LSB    = 8;
  localparam int STAT_DEN_LSB    = 16;

  // ==========================================================================
  // ladder arithmetic and comparator coupling
  // ==========================================================================
  localparam logic [5:0] LOW_DENOM     = 6'h18;
  localparam logic [5:0] HIGH_DENOM    = 6'h20;
  localparam logic [5:0] HIGH_BASE     = 6'h08;
  localparam logic [2:0] COMP_REF_MODE = 3'h6;
  localparam int         SHARED_PIN    = 2;

endpackage

/* rtl/lrc_ladder_reference_control.sv */
// ladder reference control register, avalon-mm slave and analog select outputs

// ============================================================================
// ladder reference control
// ============================================================================
// Behaviour
// - bit 7 one powers the ladder on; zero keeps it powered down
// - bit 6 one routes ladder level onto shared pin; zero disconnects it
// - while pin drive is set, the pin's direction bit is ignored
// - range bit one selects low range: tap over 24 times span
// - range bit zero selects high range: quarter span plus tap over 32
// - bit 4 one feeds ladder from reference pins, zero from supply rails
// - bits 3 to 0 hold a 4-bit tap value, 0 to 15
// - reset clears enable, pin drive, range and tap bits
// - waking from sleep leaves every control bit unchanged
// - reference works independently of the comparator block
// - ladder feeds both comparator positive inputs only in mode 110
module lrc_ladder_reference_control #(
  parameter int ADDR_WIDTH = 4,
  parameter int DATA_WIDTH = 32
) (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // avalon-mm slave
  input  wire logic [ADDR_WIDTH-1:0]   address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [DATA_WIDTH-1:0]   writedata,
  input  wire logic [DATA_WIDTH/8-1:0] byteenable,
  output logic      [DATA_WIDTH-1:0]   readdata,
  output logic                         waitrequest,
  // neighbouring port and comparator state
  input  wire logic [7:0]              portADirection,
  input  wire logic [2:0]              comparatorModeSelect,
  // analog ladder selects
  output logic                         ladderPowerOn,
  output logic                         refPinDrive,
  output logic                         rangeSelect,
  output logic                         sourceSelect,
  output logic      [3:0]              tapValue,
  output logic      [5:0]              levelNumerator,
  output logic      [5:0]              levelDenominator,
  output logic                         sharedPinDigitalOe,
  output logic                         compPosFromLadder
);

  // ==========================================================================
  // bus handshake
  // ==========================================================================
  logic                  ctrlSel;
  logic                  statSel;
  logic                  writeTaken;
  logic [7:0]            ctrlReg;
  logic [DATA_WIDTH-1:0] statusWord;
  logic [DATA_WIDTH-1:0] next_readdata;

  assign ctrlSel    = (address == ADDR_WIDTH'(lrc_pkg::CTRL_OFFSET));
  assign statSel    = (address == ADDR_WIDTH'(lrc_pkg::STATUS_OFFSET));
  assign writeTaken = write && !waitrequest;

  // one wait cycle per request, then one cycle with waitrequest low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end

  // ==========================================================================
  // control register
  // ==========================================================================
  // no sleep or wake input reaches this register, so it keeps its value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlReg <= lrc_pkg::CTRL_RESET;
    end else if (writeTaken && ctrlSel && byteenable[0]) begin
      ctrlReg <= writedata[lrc_pkg::CTRL_WIDTH-1:0];
    end
  end

  // ==========================================================================
  // read path
  // ==========================================================================
  always_comb begin
    statusWord = '0;
    statusWord[lrc_pkg::STAT_POWER_BIT]  = ladderPowerOn;
    statusWord[lrc_pkg::STAT_PIN_BIT]    = refPinDrive;
    statusWord[lrc_pkg::STAT_COMP_BIT]   = compPosFromLadder;
    statusWord[lrc_pkg::STAT_DIG_OE_BIT] = sharedPinDigitalOe;
    statusWord[lrc_pkg::STAT_NUM_LSB +: 6] = levelNumerator;
    statusWord[lrc_pkg::STAT_DEN_LSB +: 6] = levelDenominator;
  end

  always_comb begin
    next_readdata = '0;
    if (ctrlSel) begin
      next_readdata[lrc_pkg::CTRL_WIDTH-1:0] = ctrlReg;
    end else if (statSel) begin
      next_readdata = statusWord;
    end
  end

  // data is loaded during the wait cycle so it stands when waitrequest drops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= '0;
    end else if (read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  // ==========================================================================
  // ladder selects
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ladderPowerOn <= 1'b0;
      refPinDrive   <= 1'b0;
      rangeSelect   <= 1'b0;
      sourceSelect  <= 1'b0;
      tapValue      <= 4'h0;
    end else begin
      ladderPowerOn <= ctrlReg[lrc_pkg::POWER_BIT];
      refPinDrive   <= ctrlReg[lrc_pkg::PIN_DRIVE_BIT];
      rangeSelect   <= ctrlReg[lrc_pkg::RANGE_BIT];
      sourceSelect  <= ctrlReg[lrc_pkg::SOURCE_BIT];
      tapValue      <= ctrlReg[lrc_pkg::TAP_MSB:lrc_pkg::TAP_LSB];
    end
  end

  // output level as a fraction of the source span
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      levelNumerator   <= lrc_pkg::HIGH_BASE;
      levelDenominator <= lrc_pkg::HIGH_DENOM;
    end else if (ctrlReg[lrc_pkg::RANGE_BIT]) begin
      levelNumerator   <= {2'h0, ctrlReg[lrc_pkg::TAP_MSB:lrc_pkg::TAP_LSB]};
      levelDenominator <= lrc_pkg::LOW_DENOM;
    end else begin
      levelNumerator   <= lrc_pkg::HIGH_BASE
                          + {2'h0, ctrlReg[lrc_pkg::TAP_MSB:lrc_pkg::TAP_LSB]};
      levelDenominator <= lrc_pkg::HIGH_DENOM;
    end
  end

  // ==========================================================================
  // shared pin and comparator coupling
  // ==========================================================================
  // direction bit zero means output; routing the level overrides it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sharedPinDigitalOe <= 1'b0;
    end else begin
      sharedPinDigitalOe <= !ctrlReg[lrc_pkg::PIN_DRIVE_BIT]
                            && !portADirection[lrc_pkg::SHARED_PIN];
    end
  end

  // ladder runs whatever the comparator mode; only the coupling depends on it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      compPosFromLadder <= 1'b0;
    end else begin
      compPosFromLadder <= (comparatorModeSelect == lrc_pkg::COMP_REF_MODE);
    end
  end

endmodule

/* bench/lrc_monitor.sv */
// port assertions for the ladder reference control
module lrc_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        read,
  input wire logic        write,
  input wire logic        waitrequest,
  input wire logic        ladderPowerOn,
  input wire logic        refPinDrive,
  input wire logic        rangeSelect,
  input wire logic        sourceSelect,
  input wire logic        sharedPinDigitalOe,
  input wire logic        compPosFromLadder,
  input wire logic [3:0]  address,
  input wire logic [3:0]  byteenable,
  input wire logic [3:0]  tapValue,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic [7:0]  portADirection,
  input wire logic [2:0]  comparatorModeSelect,
  input wire logic [5:0]  levelNumerator,
  input wire logic [5:0]  levelDenominator
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_WAIT_ONE: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  AST_LOW: assert property (rangeSelect |->
    levelDenominator == 6'h18 && levelNumerator == tapValue)
    else $error("low range level wrong");
  AST_HIGH: assert property (!rangeSelect |->
    levelDenominator == 6'h20 && levelNumerator == 6'h08 + tapValue)
    else $error("high range level wrong");
  AST_OVERRIDE: assert property (refPinDrive |-> !sharedPinDigitalOe)
    else $error("digital drive on while level routed to pin");
  AST_DIG_OE: assert property ($past(rst_b) && !refPinDrive |->
    sharedPinDigitalOe == !$past(portADirection[2]))
    else $error("digital output enable does not follow direction");
  AST_COMP: assert property ($past(rst_b) |->
    compPosFromLadder == ($past(comparatorModeSelect) == 3'h6))
    else $error("comparator coupling wrong");
  AST_WRITE: assert property (write && !waitrequest && address == 4'h0 && byteenable[0] |->
    ##2 {ladderPowerOn, refPinDrive, rangeSelect, sourceSelect, tapValue}
    == $past(writedata[7:0], 2))
    else $error("selects do not follow control write");
  AST_READBACK: assert property (read && !waitrequest && address == 4'h0 |->
    readdata == {24'h0, ladderPowerOn, refPinDrive, rangeSelect, sourceSelect, tapValue})
    else $error("control readback wrong");
  AST_UNMAPPED: assert property (read && !waitrequest && address != 4'h0 && address != 4'h4 |->
    readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_RESET: assert property ($rose(rst_b) |-> !ladderPowerOn && !refPinDrive && !rangeSelect && tapValue == 4'h0)
    else $error("selects not cleared by reset");
endmodule

/* bench/tb.sv */
// self-checking bench for the ladder reference control
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, read, write, waitrequest, ladderPowerOn, refPinDrive, rangeSelect;
  logic        sourceSelect, sharedPinDigitalOe, compPosFromLadder;
  logic [3:0]  address, byteenable, tapValue;
  logic [31:0] writedata, readdata, expR;
  logic [7:0]  portADirection, ctrl, v;
  logic [2:0]  comparatorModeSelect;
  logic [5:0]  levelNumerator, levelDenominator, nm, dn;
  logic [21:0] expO, obs;
  logic [31:0] rdQ[$];
  logic [21:0] outQ[$];
  logic [7:0]  vals[6] = '{8'hFF, 8'h20, 8'h2F, 8'h0F, 8'h40, 8'h50};
  int          errors = 0;
  int          n_checks = 0;
  assign obs = {ladderPowerOn, refPinDrive, rangeSelect, sourceSelect, tapValue, levelNumerator,
                levelDenominator, sharedPinDigitalOe, compPosFromLadder};
  lrc_ladder_reference_control DUT (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .portADirection(portADirection),
    .comparatorModeSelect(comparatorModeSelect),
    .ladderPowerOn(ladderPowerOn), .refPinDrive(refPinDrive), .rangeSelect(rangeSelect),
    .sourceSelect(sourceSelect), .tapValue(tapValue), .levelNumerator(levelNumerator),
    .levelDenominator(levelDenominator), .sharedPinDigitalOe(sharedPinDigitalOe),
    .compPosFromLadder(compPosFromLadder));
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one avalon cycle; reads note the expected answer for the watcher
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d, logic [3:0] be);
    int i = 0;
    @(posedge clk);
    {read, write, address, writedata, byteenable} <= {!wr, wr, a, d, be};
    if (wr && a == 4'h0 && be[0]) ctrl = d[7:0];
    nm = ctrl[5] ? {2'h0, ctrl[3:0]} : 6'h08 + ctrl[3:0];
    dn = ctrl[5] ? 6'h18 : 6'h20;
    expO = {ctrl, nm, dn, !ctrl[6] && !portADirection[2], comparatorModeSelect == 3'h6};
    expR = a == 4'h0 ? {24'h0, ctrl} : a == 4'h4 ? {10'h0, dn, 2'h0, nm, 4'h0, expO[1:0],
           ctrl[6], ctrl[7]} : 32'h0;
    if (!wr) rdQ.push_back(expR);
    if (!wr) outQ.push_back(expO);
    do begin
      @(posedge clk);
      i++;
    end while (waitrequest !== 1'b0 && i < 20);
    if (waitrequest !== 1'b0) begin
      errors++;
      test_done();
    end
    {read, write} <= 2'h0;
  endtask
  always @(posedge clk) begin
    if (read === 1'b1 && waitrequest === 1'b0 && rdQ.size() > 0) begin
      chk("readdata", rdQ.pop_front(), readdata);
      chk("selects", {10'h0, outQ.pop_front()}, {10'h0, obs});
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_b, read, write, address, writedata, byteenable, portADirection, comparatorModeSelect} = '0;
    ctrl = 8'h00;
    void'($urandom(32'h5e2e));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    bus(1'b0, 4'h4, 32'h0, 4'hF);
    for (int k = 0; k < 30; k++) begin
      v = k < 6 ? vals[k] : 8'($urandom);
      portADirection <= 8'($urandom);
      comparatorModeSelect <= 3'(k);
      bus(1'b1, 4'h0, {24'($urandom), v}, 4'hF);
      bus(1'b0, 4'h0, 32'h0, 4'hF);
      bus(1'b0, 4'h4, 32'h0, 4'hF);
    end
    bus(1'b1, 4'h0, 32'h0, 4'hE);
    bus(1'b1, 4'h8, 32'h0, 4'hF);
    bus(1'b1, 4'h4, 32'h0, 4'hF);
    repeat (20) @(posedge clk);
    bus(1'b0, 4'h8, 32'h0, 4'hF);
    bus(1'b0, 4'h4, 32'h0, 4'hF);
    bus(1'b1, 4'h0, 32'h0, 4'hF);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    ctrl = 8'h00;
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    test_done();
  end
endmodule
bind lrc_ladder_reference_control lrc_monitor MON (.clk(clk), .rst_b(rst_b), .read(read),
  .write(write), .waitrequest(waitrequest), .ladderPowerOn(ladderPowerOn),
  .refPinDrive(refPinDrive),
  .rangeSelect(rangeSelect), .sourceSelect(sourceSelect), .sharedPinDigitalOe(sharedPinDigitalOe),
  .compPosFromLadder(compPosFromLadder), .address(address), .byteenable(byteenable),
  .tapValue(tapValue), .writedata(writedata), .readdata(readdata), .portADirection(portADirection),
  .comparatorModeSelect(comparatorModeSelect), .levelNumerator(levelNumerator),
  .levelDenominator(levelDenominator));
